/* apc_analog_model.sv */
// Comparator of the analog core, answering the trial code
`timescale 1ns/100ps
module apc_analog_model
	import apc_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Converter side
	input wire apc_ana_t ana,
	input wire logic [11:0] vin,
	// Comparator result
	output logic cmp_above
);
	logic idle_q = 1'b0;
	always @(posedge pclk) begin
		idle_q <= ~idle_q;
	end
	// Input sits half a step above vin so no trial code ties; junk when off
	assign cmp_above = (ana.enable && ana.active) ?
		({vin, 1'b1} > {ana.dac_code, 1'b0}) : idle_q;
endmodule

/* apc_clkgen.sv */
// Converter clock source selection and divider
`timescale 1ns/100ps
module apc_clkgen
	import apc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Configuration
	input wire logic [1:0] src_sel,
	input wire logic [1:0] div_sel,
	input wire logic run,
	// Outside clocks
	input wire logic alternate_clock,
	input wire logic internal_async_clock,
	// One pulse per converter clock period
	output logic tick
);

	logic alt_s1_q, alt_s2_q, alt_s3_q;
	logic asy_s1_q, asy_s2_q, asy_s3_q;
	logic half_q;
	logic src_tick;
	logic [2:0] cnt_q;
	logic [2:0] last;
	logic tick_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_s1_q <= 1'b0;
			alt_s2_q <= 1'b0;
			alt_s3_q <= 1'b0;
			asy_s1_q <= 1'b0;
			asy_s2_q <= 1'b0;
			asy_s3_q <= 1'b0;
		end else begin
			alt_s1_q <= alternate_clock;
			alt_s2_q <= alt_s1_q;
			alt_s3_q <= alt_s2_q;
			asy_s1_q <= internal_async_clock;
			asy_s2_q <= asy_s1_q;
			asy_s3_q <= asy_s2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end

	always_comb begin
		case (apc_src_t'(src_sel))
			SRC_BUS: src_tick = 1'b1; // [R12] [R19]
			SRC_BUS2: src_tick = half_q; // [R14]
			SRC_ALT: src_tick = alt_s2_q & ~alt_s3_q; // [R15]
			SRC_ASYNC: src_tick = asy_s2_q & ~asy_s3_q; // [R16]
			default: src_tick = 1'b1;
		endcase
	end

	// Ratio minus one: 0, 1, 3, 7
	assign last = 3'(({1'b0, 3'h1} << div_sel) - 4'h1); // [R17] [R20]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			tick_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= src_tick && (cnt_q == last);
			if (src_tick) begin
				cnt_q <= (cnt_q == last) ? 3'h0 : cnt_q + 3'h1; // [R17]
			end
		end
	end

	assign tick = tick_q;

endmodule

/* apc_fmt.sv */
// Result rounding per conversion mode and automatic compare
`timescale 1ns/100ps
module apc_fmt
	import apc_pkg::*;
(
	// Raw result and mode
	input wire logic [1:0] mode,
	input wire logic [11:0] raw,
	// Compare setup
	input wire logic [7:0] cv_hi,
	input wire logic [7:0] cv_lo,
	input wire logic cmp_gt,
	// Formatted result
	output apc_res_t res,
	output logic cmp_hit
);

	logic [9:0] r10;
	logic [7:0] r8;
	logic [11:0] val;
	logic [11:0] cv;

	// Round half up, saturating at full scale
	assign r10 = (&raw[11:2]) ? raw[11:2] : raw[11:2] + {9'h0, raw[1]}; // [R08]
	assign r8 = (&raw[11:4]) ? raw[11:4] : raw[11:4] + {7'h0, raw[3]}; // [R09]

	always_comb begin
		case (apc_mode_t'(mode)) // [R21]
			MODE_10: begin
				res.hi = {6'h0, r10[9:8]}; // [R08]
				res.lo = r10[7:0];
				cv = {2'h0, cv_hi[1:0], cv_lo};
			end
			MODE_8: begin
				res.hi = 8'h00; // [R09]
				res.lo = r8;
				cv = {4'h0, cv_lo};
			end
			default: begin
				res.hi = {4'h0, raw[11:8]};
				res.lo = raw[7:0];
				cv = {cv_hi[3:0], cv_lo};
			end
		endcase
		val = {res.hi[3:0], res.lo};
		cmp_hit = cmp_gt ? (val >= cv) : (val < cv); // [R11]
	end

endmodule

/* apc_pkg.sv */
// Constants, types and register map of the converter control block
//
// Notes on behaviour
// [R01] Pin disable register one holds bits for channels 0 to 7.
// [R02] Pin disable register two holds bits for channels 8 to 15.
// [R03] Pin disable register three holds bits for channels 16 to 23.
// [R04] Bit 0 keeps port control of the pin; bit 1 removes it.
// [R05] Converter disabled in reset and while channel select is all ones.
// [R06] Between conversions the converter stays idle at lowest power.
// [R07] Successive approximation gives 12 raw bits, or 9 in 8-bit mode.
// [R08] In 10-bit mode the raw result is rounded to 10 bits.
// [R09] In 8-bit mode the raw result is rounded to 8 bits, low only.
// [R10] Storing a result sets the complete flag; interrupt if enabled.
// [R11] Compare enable checks every result against the compare value.
// [R12] Four selectable clock sources, divided to make the converter clock.
// [R13] After reset the bus clock is the selected source.
// [R14] One source is the bus clock halved, giving division up to 16.
// [R15] One source is the alternate clock supplied from outside.
// [R16] Internal asynchronous clock keeps running in wait and stop3.
// [R17] Divider divides the selected source by 1, 2, 4 or 8.
// [R18] Software keeps the converter clock inside its allowed range.
// [R19] Source codes: 00 bus, 01 bus/2, 10 alternate, 11 asynchronous.
// [R20] Divide codes 00, 01, 10, 11 mean 1, 2, 4, 8.
// [R21] Mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// [R22] Set bit tristates pin output, blocks its input, drops pullup.
// [R23] One override output per channel comes straight from its bit.
// [R24] Interrupt stays high while flag and enable are both set.
package apc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMPCTL = 8'h04;
	localparam logic [7:0] OFS_RES_HI = 8'h08;
	localparam logic [7:0] OFS_RES_LO = 8'h0c;
	localparam logic [7:0] OFS_CV_HI = 8'h10;
	localparam logic [7:0] OFS_CV_LO = 8'h14;
	localparam logic [7:0] OFS_CFG = 8'h18;
	localparam logic [7:0] OFS_PD0 = 8'h1c;
	localparam logic [7:0] OFS_PD1 = 8'h20;
	localparam logic [7:0] OFS_PD2 = 8'h24;

	// Field positions
	localparam int CTRL_CONVERSION_COMPLETE_FLAG = 7;
	localparam int CTRL_IEN = 6;
	localparam int CTRL_CONT = 5;
	localparam int CMP_EN = 5;
	localparam int CMP_GT = 4;
	localparam int CFG_LPC = 7;
	localparam int CFG_DIV = 5;
	localparam int CFG_LSMP = 4;
	localparam int CFG_MODE = 2;
	localparam int CFG_ICLK = 0;

	// Values after reset
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_REG = 8'h00;

	// Sample phase length in converter clock ticks
	localparam logic [4:0] SAMP_SHORT = 5'h04;
	localparam logic [4:0] SAMP_LONG = 5'h18;

	// Edges to wait after a trial code before its comparator answer is used
	localparam logic [2:0] CMP_SETTLE = 3'h3;

	typedef enum logic [1:0] {
		MODE_8 = 2'b00,
		MODE_12 = 2'b01,
		MODE_10 = 2'b10,
		MODE_RSV = 2'b11
	} apc_mode_t;

	typedef enum logic [1:0] {
		SRC_BUS = 2'b00,
		SRC_BUS2 = 2'b01,
		SRC_ALT = 2'b10,
		SRC_ASYNC = 2'b11
	} apc_src_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b11,
		ST_STORE = 2'b10
	} apc_state_t;

	// Signals towards the analog core
	typedef struct packed {
		logic enable;
		logic active;
		logic sample;
		logic low_power;
		logic [4:0] channel;
		logic [11:0] dac_code;
	} apc_ana_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} apc_res_t;

endpackage

/* apc_top.sv */
// Converter control: register slave, conversion sequencer, pin override
`timescale 1ns/100ps
module apc_top
	import apc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog core
	input wire logic cmp_above,
	output apc_ana_t ana,
	output logic conv_clk_tick,
	output logic async_clk_req,
	// Outside clock sources
	input wire logic alternate_clock,
	input wire logic internal_async_clock,
	// Pad overrides, one per channel
	output logic [23:0] pin_disable,
	// Completion interrupt
	output logic irq
);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, OFS_CTRL) || hit(a, OFS_CMPCTL) ||
			hit(a, OFS_RES_HI) || hit(a, OFS_RES_LO) ||
			hit(a, OFS_CV_HI) || hit(a, OFS_CV_LO) ||
			hit(a, OFS_CFG) || hit(a, OFS_PD0) ||
			hit(a, OFS_PD1) || hit(a, OFS_PD2);
	endfunction

	// Bus state
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] rdata;
	logic wr_fire;
	logic rd_fire;
	logic ack;

	// Software registers
	logic ien_q;
	logic cont_q;
	logic [4:0] chan_q;
	logic cmp_en_q;
	logic cmp_gt_q;
	logic [7:0] cv_hi_q;
	logic [7:0] cv_lo_q;
	logic [7:0] cfg_q;
	logic [7:0] pd0_q;
	logic [7:0] pd1_q;
	logic [7:0] pd2_q;

	// Conversion state
	apc_state_t state_q;
	logic [11:0] code_q;
	logic [3:0] bit_q;
	logic [4:0] samp_q;
	apc_res_t res_q;
	logic conversion_complete_flag_q;
	logic lock_q;
	logic irq_q;
	apc_ana_t ana_q;
	logic async_req_q;
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic [2:0] settle_q;

	// Derived
	logic [1:0] mode;
	logic [3:0] lsb;
	logic tick;
	logic step;
	logic start;
	logic abort;
	logic store;
	logic blocked;
	logic store_ok;
	apc_res_t fmt_res;
	logic fmt_hit;
	logic [11:0] kept;

	assign mode = cfg_q[CFG_MODE +: 2];
	// 9-bit search stops at bit 3 so the code stays left aligned
	assign lsb = (apc_mode_t'(mode) == MODE_8) ? 4'h3 : 4'h0; // [R07]

	// Access phase is two cycles: pready rises in the second
	assign ack = psel && penable && pready_q;
	assign wr_fire = ack && pwrite;
	assign rd_fire = ack && !pwrite;

	always_comb begin
		rdata = 8'h00;
		case (paddr)
			OFS_CTRL: rdata = {conversion_complete_flag_q, ien_q, cont_q, chan_q};
			OFS_CMPCTL: rdata = {2'h0, cmp_en_q, cmp_gt_q, 4'h0};
			OFS_RES_HI: rdata = res_q.hi;
			OFS_RES_LO: rdata = res_q.lo;
			OFS_CV_HI: rdata = cv_hi_q;
			OFS_CV_LO: rdata = cv_lo_q;
			OFS_CFG: rdata = cfg_q;
			OFS_PD0: rdata = pd0_q;
			OFS_PD1: rdata = pd1_q;
			OFS_PD2: rdata = pd2_q;
			default: rdata = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q) begin
				pslverr_q <= !mapped(paddr);
				prdata_q <= pwrite ? 32'h0000_0000 : {24'h0, rdata};
			end else begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Control and compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_q <= 1'b0;
			cont_q <= 1'b0;
			chan_q <= CH_OFF;
			cmp_en_q <= 1'b0;
			cmp_gt_q <= 1'b0;
			cv_hi_q <= RST_REG;
			cv_lo_q <= RST_REG;
		end else if (wr_fire) begin
			if (hit(paddr, OFS_CTRL)) begin
				ien_q <= pwdata[CTRL_IEN];
				cont_q <= pwdata[CTRL_CONT];
				chan_q <= pwdata[4:0];
			end
			if (hit(paddr, OFS_CMPCTL)) begin
				cmp_en_q <= pwdata[CMP_EN]; // [R11]
				cmp_gt_q <= pwdata[CMP_GT];
			end
			if (hit(paddr, OFS_CV_HI)) begin
				cv_hi_q <= pwdata[7:0];
			end
			if (hit(paddr, OFS_CV_LO)) begin
				cv_lo_q <= pwdata[7:0];
			end
		end
	end

	// Configuration; source select comes out of reset on the bus clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= RST_CFG; // [R13]
		end else if (wr_fire && hit(paddr, OFS_CFG)) begin
			cfg_q <= pwdata[7:0];
		end
	end

	// Pin disable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd0_q <= RST_REG;
			pd1_q <= RST_REG;
			pd2_q <= RST_REG;
		end else if (wr_fire) begin
			if (hit(paddr, OFS_PD0)) begin
				pd0_q <= pwdata[7:0]; // [R01]
			end
			if (hit(paddr, OFS_PD1)) begin
				pd1_q <= pwdata[7:0]; // [R02]
			end
			if (hit(paddr, OFS_PD2)) begin
				pd2_q <= pwdata[7:0]; // [R03]
			end
		end
	end

	// Bit n high takes pad n away from port control
	assign pin_disable = {pd2_q, pd1_q, pd0_q}; // [R04] [R22] [R23]

	// Comparator output from the analog core is asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_above;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	apc_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.src_sel(cfg_q[CFG_ICLK +: 2]),
		.div_sel(cfg_q[CFG_DIV +: 2]),
		.run(state_q != ST_IDLE),
		.alternate_clock(alternate_clock),
		.internal_async_clock(internal_async_clock),
		.tick(tick)
	);

	apc_fmt u_fmt (
		.mode(mode),
		.raw(code_q),
		.cv_hi(cv_hi_q),
		.cv_lo(cv_lo_q),
		.cmp_gt(cmp_gt_q),
		.res(fmt_res),
		.cmp_hit(fmt_hit)
	);

	// Any write to control, compare or configuration restarts or stops
	assign start = wr_fire && hit(paddr, OFS_CTRL) &&
		(pwdata[4:0] != CH_OFF);
	assign abort = wr_fire && (hit(paddr, OFS_CTRL) ||
		hit(paddr, OFS_CMPCTL) || hit(paddr, OFS_CV_HI) ||
		hit(paddr, OFS_CV_LO) || hit(paddr, OFS_CFG));
	assign store = (state_q == ST_STORE) && !abort;
	assign blocked = lock_q && (apc_mode_t'(mode) != MODE_8);
	assign store_ok = store && !blocked && (!cmp_en_q || fmt_hit); // [R11]
	// Trial bit survives only when the input is above the trial level
	assign kept = cmp_s2_q ? code_q : (code_q & ~(12'h001 << bit_q));
	// Register out, core and two sync stages: decide only once settled
	assign step = tick && (settle_q == 3'h0); // [R07]

	// Successive approximation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			code_q <= 12'h000;
			bit_q <= 4'h0;
			samp_q <= 5'h00;
			settle_q <= 3'h0;
		end else if (start) begin
			state_q <= ST_SAMPLE;
			code_q <= 12'h000;
			bit_q <= 4'hb;
			samp_q <= cfg_q[CFG_LSMP] ? SAMP_LONG : SAMP_SHORT;
		end else if (abort) begin
			state_q <= ST_IDLE; // [R05]
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_IDLE; // [R06]
				end
				ST_SAMPLE: begin
					if (tick) begin
						samp_q <= samp_q - 5'h01;
						if (samp_q == 5'h01) begin
							state_q <= ST_CONVERT;
							settle_q <= CMP_SETTLE;
							code_q <= 12'h800;
							bit_q <= 4'hb;
						end
					end
				end
				ST_CONVERT: begin
					if (step) begin
						settle_q <= CMP_SETTLE;
						if (bit_q == lsb) begin
							code_q <= kept; // [R07]
							state_q <= ST_STORE;
						end else begin
							code_q <= kept | (12'h001 << (bit_q - 4'h1));
							bit_q <= bit_q - 4'h1;
						end
					end else if (settle_q != 3'h0) begin
						settle_q <= settle_q - 3'h1;
					end
				end
				ST_STORE: begin
					// A blocked result is dropped and another one started
					if (blocked || cont_q) begin
						state_q <= ST_SAMPLE;
						code_q <= 12'h000;
						samp_q <= cfg_q[CFG_LSMP] ? SAMP_LONG : SAMP_SHORT;
					end else begin
						state_q <= ST_IDLE; // [R06]
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Result registers change only when a result is accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= '0;
		end else if (store_ok) begin
			res_q <= fmt_res; // [R08] [R09]
		end
	end

	// Reading the high byte outside 8-bit mode holds off new results until the low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q <= 1'b0;
		end else if (rd_fire && hit(paddr, OFS_RES_LO)) begin
			lock_q <= 1'b0;
		end else if (rd_fire && hit(paddr, OFS_RES_HI) &&
			(apc_mode_t'(mode) != MODE_8)) begin
			lock_q <= 1'b1;
		end
	end

	// Complete flag: a new result wins over the clearing read of the low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_complete_flag_q <= 1'b0;
		end else if (store_ok) begin
			conversion_complete_flag_q <= 1'b1; // [R10]
		end else if (abort || (rd_fire && hit(paddr, OFS_RES_LO))) begin
			conversion_complete_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= conversion_complete_flag_q && ien_q; // [R10] [R24]
		end
	end

	// Analog core controls, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana_q <= '0; // [R05]
			async_req_q <= 1'b0;
		end else begin
			ana_q.enable <= (chan_q != CH_OFF); // [R05]
			ana_q.active <= (state_q != ST_IDLE); // [R06]
			ana_q.sample <= (state_q == ST_SAMPLE);
			ana_q.low_power <= cfg_q[CFG_LPC];
			ana_q.channel <= chan_q;
			ana_q.dac_code <= code_q;
			// Request ignores wait and stop3 so the source keeps running
			async_req_q <= (state_q != ST_IDLE) &&
				(apc_src_t'(cfg_q[CFG_ICLK +: 2]) == SRC_ASYNC); // [R16]
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ana = ana_q;
	assign conv_clk_tick = tick; // [R12]
	assign async_clk_req = async_req_q;
	assign irq = irq_q;

endmodule

/* apc_top_props.sv */
// Port assertions for the converter control block
`timescale 1ns/100ps
module apc_top_chk
	import apc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Analog side, clocks, pads
	input wire logic cmp_above,
	input wire apc_ana_t ana,
	input wire logic conv_clk_tick,
	input wire logic async_clk_req,
	input wire logic alternate_clock,
	input wire logic internal_async_clock,
	input wire logic [23:0] pin_disable,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pready && pwrite;
	AST_PD0_WR: assert property (wr && paddr == OFS_PD0 |=>
		pin_disable[7:0] == $past(pwdata[7:0]))
		else $error("pin override 0-7 not loaded");
	AST_PD1_WR: assert property (wr && paddr == OFS_PD1 |=>
		pin_disable[15:8] == $past(pwdata[7:0]))
		else $error("pin override 8-15 not loaded");
	AST_PD2_WR: assert property (wr && paddr == OFS_PD2 |=>
		pin_disable[23:16] == $past(pwdata[7:0]))
		else $error("pin override 16-23 not loaded");
	AST_PIN_HOLD: assert property (!wr |=> $stable(pin_disable))
		else $error("pin override changed without a write");
	AST_IRQ_HOLD: assert property (irq && !pready && !$past(pready)
		|=> irq)
		else $error("irq dropped without an access");
	AST_IRQ_EN: assert property (wr && paddr == OFS_CTRL
		&& !pwdata[CTRL_IEN] |-> ##2 !irq)
		else $error("irq high with enable cleared");
	AST_OFF: assert property (wr && paddr == OFS_CTRL
		&& pwdata[4:0] == CH_OFF |-> ##2 (!ana.enable && !ana.active))
		else $error("converter still enabled with channel off");
	AST_SAMPLE: assert property (ana.sample |-> ana.active && ana.enable)
		else $error("sampling while idle");
	AST_TICK: assert property (conv_clk_tick |-> ##[0:2] ana.active)
		else $error("converter clock runs while idle");
	AST_ASYNC: assert property ($rose(async_clk_req)
		|-> ##[0:2] ana.active)
		else $error("async clock requested while idle");
	cover property (wr && paddr == OFS_PD2);
	cover property ($rose(irq));
	cover property (async_clk_req);
	cover property (pready && pslverr);
endmodule
bind apc_top apc_top_chk apc_top_chk_i (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cmp_above(cmp_above), .ana(ana), .conv_clk_tick(conv_clk_tick),
	.async_clk_req(async_clk_req), .alternate_clock(alternate_clock),
	.internal_async_clock(internal_async_clock),
	.pin_disable(pin_disable), .irq(irq));

/* tb_adc_pin_control_and_clock_select.sv */
// Testbench for the converter control block
`timescale 1ns/100ps
module tb_adc_pin_control_and_clock_select
	import apc_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, cmp_above, conv_clk_tick, async_clk_req, irq, e;
	logic alt_clk = 0, osc_clk = 0;
	logic [11:0] vin = 12'h000;
	logic [23:0] pin_disable;
	apc_ana_t ana;
	int fails = 0, n_compared = 0, cyc = 0, last_tk = 0, gap = 0, i;
	logic [7:0] cfgv [4] = '{8'h00, 8'hb9, 8'h46, 8'h67};
	logic [7:0] hiv [4] = '{8'h00, 8'h02, 8'h0a, 8'h0a};
	logic [7:0] lov [4] = '{8'hac, 8'hae, 8'hb8, 8'hb8};
	int gapv [4] = '{1, 4, 20, 56};

	apc_top apc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_above(cmp_above), .ana(ana), .conv_clk_tick(conv_clk_tick),
		.async_clk_req(async_clk_req), .alternate_clock(alt_clk),
		.internal_async_clock(osc_clk), .pin_disable(pin_disable), .irq(irq));
	apc_analog_model apc_analog_model_i (.pclk(pclk), .ana(ana), .vin(vin),
		.cmp_above(cmp_above));

	always #20 pclk = ~pclk;
	initial begin
		#7;
		forever #100 alt_clk = ~alt_clk;
	end
	initial begin
		#3;
		forever #140 osc_clk = ~osc_clk;
	end

	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Tick spacing inside a conversion, and the hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (conv_clk_tick === 1'b1) begin
			gap <= cyc - last_tk;
			last_tk <= cyc;
		end
		if (cyc == 20000) begin
			fails = fails + 1;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	task automatic run_one;
		while (ana.active !== 1'b1) @(posedge pclk);
		while (ana.active !== 1'b0) @(posedge pclk);
		repeat (3) @(posedge pclk);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CFG, 32'h0);
		for (i = 0; i < 3; i++) rd(8'(OFS_PD0 + 4 * i), 32'h0);
		$display("Test reset values done");
		wr(OFS_PD0, 8'ha5);
		wr(OFS_PD1, 8'h3c);
		wr(OFS_PD2, 8'h81);
		chk(32'(pin_disable), 32'h00813ca5);
		rd(OFS_PD1, 32'h3c);
		apb(1'b0, 8'h28, 32'h0);
		chk(32'(e), 32'h1);
		wr(OFS_PD0, 8'h00);
		chk(32'(pin_disable), 32'h00813c00);
		$display("Test pin overrides done");
		vin <= 12'hab8;
		for (i = 0; i < 4; i++) begin
			if (i > 0) wr(OFS_CFG, cfgv[i]);
			wr(OFS_CTRL, 8'h45);
			@(posedge pclk);
			chk({25'h0, ana.low_power, async_clk_req, ana.channel},
				{25'h0, cfgv[i][7], i == 3, 5'h05});
			while (irq !== 1'b1) @(posedge pclk);
			repeat (3) @(posedge pclk);
			chk(32'(irq), 32'h1);
			chk(gap, gapv[i]);
			rd(OFS_CTRL, 32'hc5);
			rd(OFS_RES_HI, {24'h0, hiv[i]});
			rd(OFS_RES_LO, {24'h0, lov[i]});
			@(posedge pclk);
			chk(32'(irq), 32'h0);
			chk(32'(ana.active), 32'h0);
		end
		$display("Test modes and clocks done");
		wr(OFS_CFG, 8'h04);
		wr(OFS_CV_HI, 8'h0f);
		wr(OFS_CV_LO, 8'h00);
		wr(OFS_CMPCTL, 8'h30);
		wr(OFS_CTRL, 8'h05);
		run_one();
		rd(OFS_CTRL, 32'h05);
		vin <= 12'h3c1;
		wr(OFS_CMPCTL, 8'h20);
		wr(OFS_CTRL, 8'h05);
		run_one();
		chk(32'(irq), 32'h0);
		rd(OFS_CTRL, 32'h85);
		rd(OFS_RES_HI, 32'h03);
		rd(OFS_RES_LO, 32'hc1);
		$display("Test compare done");
		wr(OFS_CTRL, 8'h65);
		while (irq !== 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk(32'(ana.active), 32'h1);
		wr(OFS_CTRL, 8'h1f);
		repeat (2) @(posedge pclk);
		chk(32'(ana.enable), 32'h0);
		chk(32'(ana.active), 32'h0);
		$display("Test disable done");
		finish_test();
	end
endmodule
